/* mbi_cfg.svh */
// Constants of the processor memory bus interface
`ifndef MBI_CFG_SVH
`define MBI_CFG_SVH
`define MBI_CT_NONSEQ 2'b00
`define MBI_CT_SEQ 2'b01
`define MBI_CT_INTERNAL 2'b10
`define MBI_CT_COPROC 2'b11
`define MBI_WORD_STEP 32'h0000_0004
`define MBI_WORD_MASK 32'hffff_fffc
`define MBI_BUF_DEPTH 2'h2
`define MBI_LANE_SHIFT 2'h3
`define MBI_LANE_MAX 2'h3
`endif

/* mbi_pkg.sv */
// Types of the processor memory bus interface
package mbi_pkg;
  // One-hot request kinds from the core
  typedef enum logic [6:0] {
    MBI_FETCH = 7'h01,
    MBI_LD_WORD = 7'h02,
    MBI_LD_BYTE = 7'h04,
    MBI_ST_WORD = 7'h08,
    MBI_ST_BYTE = 7'h10,
    MBI_INTERNAL = 7'h20,
    MBI_COPROC = 7'h40
  } mbi_kind_t;

  // One queued or staged bus cycle
  typedef struct packed {
    logic vld;
    mbi_kind_t kind;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mbi_cyc_t;

  // All state of the interface
  typedef struct packed {
    mbi_cyc_t [1:0] q;
    logic [1:0] cnt;
    mbi_cyc_t fc;
    mbi_cyc_t cur;
    logic [31:0] last_addr;
    logic [31:0] addr;
    logic [31:0] addr_pin;
    logic mreq_n;
    logic seq;
    logic bw_n;
    logic rw;
    logic [31:0] dout;
    logic doe;
    logic wait_s1;
    logic wait_s2;
    logic ale_s1;
    logic ale_s2;
    logic [31:0] din_s1;
    logic [31:0] din_s2;
    logic [3:0] pend0;
    logic [3:0] pend1;
    logic [31:0] rdata;
    logic rvalid;
    logic go_d;
  } mbi_state_t;
endpackage : mbi_pkg

/* mbi_top.sv */
// Processor-side memory bus interface with cycle forecasting and byte lanes
`timescale 1ns/1ps
`include "mbi_cfg.svh"
module mbi_top
  import mbi_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // Asynchronous reset, high
  input wire logic req_valid, // Core offers a cycle
  output logic req_ready, // Buffer has room
  input wire mbi_pkg::mbi_kind_t req_kind, // Kind of offered cycle
  input wire logic [31:0] req_addr, // Byte address of offered cycle
  input wire logic [31:0] req_wdata, // Store data, byte in bits 7..0
  input wire logic big_endian, // Lane order select, steady level
  output logic rd_valid, // Load data pulse
  output logic [31:0] rd_data, // Load word or zero-extended byte
  output logic [31:0] addr_out, // Address pins
  output logic [31:0] data_out, // Data pins, driven value
  output logic data_oe, // Data pins driven
  input wire logic [31:0] data_in, // Data pins, sampled value
  output logic read_write_dir, // High for a write
  output logic byte_word_sel_n, // Low for a byte transfer
  output logic memory_request_n, // Cycle type, high bit
  output logic sequential_flag, // Cycle type, low bit
  input wire logic wait_req_n, // Low stretches the cycle
  input wire logic ale // High lets the address through
);
  import mbi_pkg::*;

  mbi_state_t r;
  mbi_state_t n;
  logic go;
  logic push;
  logic pop;
  logic [1:0] lane;
  mbi_cyc_t head;

  always_comb begin
    n = r;
    n.wait_s1 = wait_req_n;
    n.wait_s2 = r.wait_s1;
    n.ale_s1 = ale;
    n.ale_s2 = r.ale_s1;
    n.din_s1 = data_in;
    n.din_s2 = r.din_s1;
    n.rvalid = 1'b0;
    lane = 2'h0;
    go = r.wait_s2;
    n.go_d = go;
    push = req_valid && (r.cnt < `MBI_BUF_DEPTH);
    pop = go && (r.cnt != 2'h0);
    head = r.q[0];
    if (pop) begin
      n.q[0] = r.q[1];
      n.q[1].vld = 1'b0;
    end
    if (push) begin
      if (r.cnt - {1'b0, pop} == 2'h0) begin
        n.q[0] = '{vld: 1'b1, kind: req_kind, addr: req_addr, wdata: req_wdata};
      end else begin
        n.q[1] = '{vld: 1'b1, kind: req_kind, addr: req_addr, wdata: req_wdata};
      end
    end
    n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    // Data sampled at the end of a load passes two stages before use
    n.pend0 = 4'h0;
    n.pend1 = r.pend0;
    if (go) begin
      // executed cycle is the forecast one
      n.cur = r.fc;
      n.fc = pop ? head : mbi_cyc_t'{vld: 1'b0, kind: MBI_INTERNAL, addr: r.addr, wdata: 32'h0};
      if (r.cur.vld && (r.cur.kind == MBI_LD_WORD || r.cur.kind == MBI_LD_BYTE
          || r.cur.kind == MBI_FETCH)) begin
        lane = big_endian ? (`MBI_LANE_MAX - r.cur.addr[1:0]) : r.cur.addr[1:0];
        n.pend0 = {1'b1, r.cur.kind == MBI_LD_BYTE, lane};
      end
      n.last_addr = r.addr;
      if (!n.fc.vld || n.fc.kind == MBI_INTERNAL) begin
        {n.mreq_n, n.seq} = `MBI_CT_INTERNAL;
        n.addr = r.addr;
      end else if (n.fc.kind == MBI_COPROC) begin
        {n.mreq_n, n.seq} = `MBI_CT_COPROC;
        n.addr = r.addr;
      end else begin
        // fetch address low bits forced clear
        n.addr = (n.fc.kind == MBI_FETCH) ? (n.fc.addr & `MBI_WORD_MASK) : n.fc.addr;
        // same word or next word only
        // same or following word after an N cycle too
        if (n.addr == r.addr || n.addr == r.addr + `MBI_WORD_STEP) begin
          {n.mreq_n, n.seq} = `MBI_CT_SEQ;
        end else begin
          {n.mreq_n, n.seq} = `MBI_CT_NONSEQ;
        end
      end
      // only byte loads and stores ask for bytes
      n.bw_n = !(n.fc.vld && (n.fc.kind == MBI_LD_BYTE || n.fc.kind == MBI_ST_BYTE));
      n.rw = n.fc.vld && (n.fc.kind == MBI_ST_WORD || n.fc.kind == MBI_ST_BYTE);
      n.doe = n.cur.vld && (n.cur.kind == MBI_ST_WORD || n.cur.kind == MBI_ST_BYTE
              || n.cur.kind == MBI_COPROC);
      n.dout = (n.cur.kind == MBI_ST_BYTE) ? {4{n.cur.wdata[7:0]}} : n.cur.wdata;
    end
    // latch closed while enable is low
    if (r.ale_s2) begin
      n.addr_pin = n.addr;
    end
    if (r.pend1[3]) begin
      n.rvalid = 1'b1;
      if (r.pend1[2]) begin
        n.rdata = {24'h0, 8'(r.din_s2 >> (5'(r.pend1[1:0]) << `MBI_LANE_SHIFT))};
      end else begin
        n.rdata = r.din_s2;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.fc.kind <= MBI_INTERNAL;
      r.cur.kind <= MBI_INTERNAL;
      r.mreq_n <= 1'b1;
      r.bw_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign req_ready = (r.cnt < `MBI_BUF_DEPTH);
  assign rd_valid = r.rvalid;
  assign rd_data = r.rdata;
  assign addr_out = r.addr_pin;
  assign data_out = r.dout;
  assign data_oe = r.doe;
  assign read_write_dir = r.rw;
  assign byte_word_sel_n = r.bw_n;
  assign memory_request_n = r.mreq_n;
  assign sequential_flag = r.seq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_internal;
    !r.fc.vld |-> (memory_request_n && !sequential_flag);
  endproperty
  a_internal: assert property (p_internal) else $error("idle not internal");

  property p_coproc;
    (r.fc.vld && r.fc.kind == MBI_COPROC) |-> (memory_request_n && sequential_flag);
  endproperty
  a_coproc: assert property (p_coproc) else $error("coproc type wrong");

  property p_seq_rel;
    (r.go_d && !memory_request_n && sequential_flag)
      |-> (r.addr == r.last_addr || r.addr == r.last_addr + `MBI_WORD_STEP);
  endproperty
  a_seq_rel: assert property (p_seq_rel) else $error("seq address unrelated");

  property p_nonseq;
    (r.go_d && !memory_request_n && !sequential_flag)
      |-> (r.addr != r.last_addr && r.addr != r.last_addr + `MBI_WORD_STEP);
  endproperty
  a_nonseq: assert property (p_nonseq) else $error("N cycle on related address");

  property p_forecast;
    (go && r.fc.vld) |=> (r.cur.vld && r.cur.kind == $past(r.fc.kind));
  endproperty
  a_forecast: assert property (p_forecast) else $error("cycle differs from forecast");

  property p_hold;
    !go |=> ($stable(memory_request_n) && $stable(sequential_flag) && $stable(r.cur));
  endproperty
  a_hold: assert property (p_hold) else $error("cycle moved during wait");

  property p_bw;
    byte_word_sel_n == !(r.fc.vld && (r.fc.kind == MBI_LD_BYTE || r.fc.kind == MBI_ST_BYTE));
  endproperty
  a_bw: assert property (p_bw) else $error("byte line wrong");

  property p_rep;
    (data_oe && r.cur.kind == MBI_ST_BYTE) |-> (data_out == {4{data_out[7:0]}});
  endproperty
  a_rep: assert property (p_rep) else $error("byte not replicated");

  property p_fetch;
    (r.fc.vld && r.fc.kind == MBI_FETCH) |-> (byte_word_sel_n && r.addr[1:0] == 2'h0);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not a word");

  property p_latch;
    !r.ale_s2 |=> $stable(addr_out);
  endproperty
  a_latch: assert property (p_latch) else $error("address moved while latched");

  property p_rd;
    (go && r.cur.vld && r.cur.kind == MBI_LD_WORD) |-> ##3 (rd_valid && rd_data == $past(data_in, 3));
  endproperty
  a_rd: assert property (p_rd) else $error("load data lost");

  property p_rw;
    r.go_d |-> (read_write_dir == (r.fc.vld && (r.fc.kind == MBI_ST_WORD
      || r.fc.kind == MBI_ST_BYTE)));
  endproperty
  a_rw: assert property (p_rw) else $error("direction wrong");

  property p_idle_addr;
    (r.go_d && memory_request_n) |-> (r.addr == r.last_addr);
  endproperty
  a_idle_addr: assert property (p_idle_addr) else $error("idle cycle moved address");

  property p_bw_idle;
    !r.fc.vld |-> byte_word_sel_n;
  endproperty
  a_bw_idle: assert property (p_bw_idle) else $error("byte line low when idle");

  property p_rw_idle;
    !r.fc.vld |-> !read_write_dir;
  endproperty
  a_rw_idle: assert property (p_rw_idle) else $error("write shown when idle");

  property p_c_no_mem;
    (memory_request_n && sequential_flag) |-> (!read_write_dir && byte_word_sel_n);
  endproperty
  a_c_no_mem: assert property (p_c_no_mem) else $error("memory qualifiers on C cycle");

  property p_oe_kind;
    data_oe |-> (r.cur.vld && (r.cur.kind == MBI_ST_WORD || r.cur.kind == MBI_ST_BYTE
      || r.cur.kind == MBI_COPROC));
  endproperty
  a_oe_kind: assert property (p_oe_kind) else $error("data driven on a read");

  property p_dout_word;
    (data_oe && r.cur.kind == MBI_ST_WORD) |-> (data_out == r.cur.wdata);
  endproperty
  a_dout_word: assert property (p_dout_word) else $error("store word wrong");

  property p_byte_lane;
    (data_oe && r.cur.kind == MBI_ST_BYTE) |-> (data_out[7:0] == r.cur.wdata[7:0]);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("store byte wrong");

  property p_rdb;
    (go && r.cur.vld && r.cur.kind == MBI_LD_BYTE) |-> ##3 (rd_valid && rd_data[31:8] == 24'h0);
  endproperty
  a_rdb: assert property (p_rdb) else $error("byte load not extended");

  property p_rd_src;
    rd_valid |-> $past(r.pend0[3], 2);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("load data without load");

  property p_addr_open;
    r.ale_s2 |=> (addr_out == r.addr);
  endproperty
  a_addr_open: assert property (p_addr_open) else $error("open latch lags address");

  property p_fetch_rd;
    (go && r.cur.vld && r.cur.kind == MBI_FETCH) |-> ##3 rd_valid;
  endproperty
  a_fetch_rd: assert property (p_fetch_rd) else $error("fetch word lost");

  property p_mem_kind;
    !memory_request_n |-> (r.fc.vld && r.fc.kind != MBI_INTERNAL && r.fc.kind != MBI_COPROC);
  endproperty
  a_mem_kind: assert property (p_mem_kind) else $error("memory cycle without transfer");

  property p_n_step;
    (r.go_d && !memory_request_n && sequential_flag && $past(!memory_request_n && !sequential_flag))
      |-> (r.addr == r.last_addr || r.addr == r.last_addr + `MBI_WORD_STEP);
  endproperty
  a_n_step: assert property (p_n_step) else $error("S after N not next word");

  property p_hold_addr;
    !go |=> ($stable(r.addr) && $stable(read_write_dir) && $stable(byte_word_sel_n));
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("qualifiers moved during wait");
endmodule : mbi_top

/* mbi_mem_model.sv */
// Memory controller model: word source, wait stretching, latch enable
`timescale 1ns/1ps
module mbi_mem_model #(
  parameter logic [31:0] MEM_WORD = 32'hc3a5_7e19,
  parameter int PAGE_BITS = 10
) (
  input wire logic clk, // Bus clock
  input wire logic rst, // Reset, high
  input wire logic [1:0] stall_mode, // 0 none, 1 random, 2 hold
  input wire logic ale_low, // Close the address latch
  input wire logic data_oe, // Device drives data
  input wire logic [31:0] data_out, // Device data value
  input wire logic [31:0] addr_out, // Device address
  input wire logic memory_request_n, // Cycle type, high bit
  input wire logic sequential_flag, // Cycle type, low bit
  output logic [31:0] data_in, // Resolved data bus
  output logic wait_req_n, // Stretch request
  output logic ale // Latch enable
);
  integer seed = 32'h578d;
  logic prev_n;
  logic page_end;
  // last word of a page after N cannot use page mode
  assign page_end = prev_n && !memory_request_n && sequential_flag
    && (&addr_out[PAGE_BITS-1:2]);
  assign data_in = data_oe ? data_out : MEM_WORD;
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      wait_req_n <= 1'b1;
      ale <= 1'b1;
      prev_n <= 1'b0;
    end else begin
      prev_n <= !memory_request_n && !sequential_flag;
      // Page ends stretched only in random mode, where the bench tolerates waits
      if (stall_mode == 2'h1) wait_req_n <= (($random(seed) & 3) != 0) && !page_end;
      else wait_req_n <= (stall_mode != 2'h2);
      ale <= !ale_low;
    end
  end
endmodule : mbi_mem_model

/* tb_top.sv */
// Self-checking bench of the memory bus interface
`timescale 1ns/1ps
`include "mbi_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import mbi_pkg::*;
  typedef struct {logic [1:0] ty; logic [31:0] a; logic bw; logic rw; logic [31:0] d;} mbi_exp_t;
  localparam logic [31:0] MEM_WORD = 32'hc3a5_7e19;
  logic clk = 0, rst = 1, req_valid = 0, big_endian = 0, ale_low = 0, mon_on = 0;
  logic prev_ok = 0, prev_st = 0, prev_c = 0, req_ready, rd_valid, data_oe, read_write_dir;
  logic byte_word_sel_n, memory_request_n, sequential_flag, wait_req_n, ale;
  logic [1:0] stall_mode = 0;
  mbi_kind_t req_kind = MBI_INTERNAL;
  logic [31:0] req_addr = 0, req_wdata = 0, last_a = 0, prev_d = 0, a0, x;
  logic [31:0] rd_data, addr_out, data_out, data_in;
  integer seed = 32'h578d;
  int mismatches = 0, total_checks = 0;
  mbi_exp_t e, fq[$];
  logic [31:0] rq[$];
  mbi_top i_mbi_top (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .big_endian(big_endian),
    .rd_valid(rd_valid), .rd_data(rd_data), .addr_out(addr_out), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .read_write_dir(read_write_dir),
    .byte_word_sel_n(byte_word_sel_n), .memory_request_n(memory_request_n),
    .sequential_flag(sequential_flag), .wait_req_n(wait_req_n), .ale(ale));
  mbi_mem_model #(.MEM_WORD(MEM_WORD)) i_mbi_mem_model (.clk(clk), .rst(rst),
    .stall_mode(stall_mode), .ale_low(ale_low), .data_oe(data_oe), .data_out(data_out),
    .addr_out(addr_out), .memory_request_n(memory_request_n),
    .sequential_flag(sequential_flag),
    .data_in(data_in), .wait_req_n(wait_req_n), .ale(ale));
  always #25 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  function automatic logic [31:0] exp_rd(mbi_kind_t k, logic [1:0] o);
    logic [1:0] lane;
    lane = big_endian ? 2'h3 - o : o;
    return (k == MBI_LD_BYTE) ? {24'h0, MEM_WORD[lane * 8 +: 8]} : MEM_WORD;
  endfunction : exp_rd
  task automatic idle(int n);
    req_valid = 0;
    repeat (n) @(posedge clk);
    #2;
  endtask : idle
  // Offer one cycle and hold it until taken; the forecast follows from the address history
  task automatic send(mbi_kind_t k, logic [31:0] a, logic [31:0] d);
    mbi_exp_t t;
    logic mem;
    logic [31:0] w;
    mem = !(k inside {MBI_INTERNAL, MBI_COPROC});
    w = (k == MBI_FETCH) ? (a & `MBI_WORD_MASK) : a;
    t.ty = !mem ? ((k == MBI_COPROC) ? `MBI_CT_COPROC : `MBI_CT_INTERNAL)
      : (w == last_a || w == last_a + `MBI_WORD_STEP) ? `MBI_CT_SEQ : `MBI_CT_NONSEQ;
    t.a = mem ? w : last_a;
    t.bw = !(k inside {MBI_LD_BYTE, MBI_ST_BYTE});
    t.rw = k inside {MBI_ST_WORD, MBI_ST_BYTE};
    t.d = (k == MBI_ST_BYTE) ? {4{d[7:0]}} : d;
    if (mem) last_a = w;
    if (mon_on && k != MBI_INTERNAL) fq.push_back(t);
    if (k inside {MBI_FETCH, MBI_LD_WORD, MBI_LD_BYTE}) rq.push_back(exp_rd(k, w[1:0]));
    req_valid = 1;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    // Ready is looked at while settled, before the edge that takes the request
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    #2;
  endtask : send
  task automatic rnd(int n);
    mbi_kind_t k;
    logic [31:0] a;
    repeat (n) begin
      k = mbi_kind_t'(7'h01 << ($unsigned($random(seed)) % 7));
      a = ($random(seed) & 1) ? last_a + ((($random(seed) & 1) != 0) ? 4 : 0) : $random(seed);
      if (!(k inside {MBI_LD_BYTE, MBI_ST_BYTE, MBI_FETCH})) a = a & `MBI_WORD_MASK;
      send(k, a, $random(seed));
      if (($random(seed) & 3) == 0) idle(1);
    end
    idle(40);
  endtask : rnd
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      x = (rq.size() > 0) ? rq.pop_front() : ~MEM_WORD;
      `CHK(rd_data, x)
    end
    if (mon_on) begin
      if (prev_ok && !prev_c) begin
        `CHK(data_oe, prev_st)
        if (prev_st) `CHK(data_out, prev_d)
      end
      {prev_ok, prev_st, prev_c} = 3'b100;
      if ({memory_request_n, sequential_flag} !== `MBI_CT_INTERNAL) begin
        e = (fq.size() > 0) ? fq.pop_front() : '{2'h2, 0, 0, 0, 0};
        `CHK({memory_request_n, sequential_flag}, e.ty)
        `CHK(addr_out, e.a)
        `CHK({byte_word_sel_n, read_write_dir}, {e.bw, e.rw})
        {prev_st, prev_c, prev_d} = {e.rw, e.ty == `MBI_CT_COPROC, e.d};
      end
    end else prev_ok = 0;
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 rst = 0;
    @(negedge clk);
    `CHK({memory_request_n, sequential_flag, byte_word_sel_n, data_oe, req_ready}, 5'b10101)
    `CHK(addr_out, 32'h0)
    idle(4);
    mon_on = 1;
    send(MBI_LD_WORD, 32'h100, 0);
    send(MBI_ST_WORD, 32'h104, 32'h1234_5678);
    send(MBI_LD_WORD, 32'h104, 0);
    send(MBI_COPROC, 32'h0, 32'h9);
    send(MBI_LD_WORD, 32'h104, 0);
    send(MBI_FETCH, 32'h203, 0);
    for (int o = 0; o < 4; o++) send(MBI_ST_BYTE, 32'h300 + o, $random(seed));
    idle(12);
    for (int b = 0; b < 2; b++) begin
      big_endian = b[0];
      for (int o = 0; o < 4; o++) send(MBI_LD_BYTE, 32'h400 + o, 0);
      idle(12);
    end
    rnd(60);
    mon_on = 0;
    $display("stream test done");
    stall_mode = 2;
    idle(6);
    send(MBI_LD_WORD, 32'h500, 0);
    send(MBI_FETCH, 32'h504, 0);
    fork
      send(MBI_LD_BYTE, 32'h509, 0);
      begin
        repeat (8) @(posedge clk);
        #2;
        `CHK(req_ready, 1'b0)
        stall_mode = 0;
      end
    join
    idle(12);
    stall_mode = 1;
    rnd(40);
    stall_mode = 0;
    idle(20);
    $display("stall test done");
    ale_low = 1;
    idle(4);
    a0 = addr_out;
    send(MBI_LD_WORD, a0 ^ 32'h1000, 0);
    idle(8);
    `CHK(addr_out, a0)
    ale_low = 0;
    idle(8);
    `CHK(addr_out, a0 ^ 32'h1000)
    `CHK(rq.size(), 0)
    $display("latch test done");
    final_report();
  end
  initial begin
    #(50 * 30000);
    mismatches++;
    final_report();
  end
endmodule : tb_top
